// ---- hdl/fcs_pkg.sv ----
// package: constants, register layout and types of the clock source unit
//==========================================================================
// Behaviour
// - system clock enable runs at twice the bus clock enable rate
// - control one bits 1 and 2 always read back as one
// - internal or external reference up to 5 MHz feeds the loop
// - internal reference period is set by nine trim bits
// - selected source divided by 1, 2, 4 or 8 from a two-bit field
// - debug clock is the controlled oscillator divided by two
// - reset leaves the unit in loop engaged internal mode
// - engaged internal: loop on internal reference drives output and debug
// - engaged external: loop on external reference drives output and debug
// - bypass internal: loop runs, internal reference drives output
// - bypass internal low power: loop and debug clock off unless debug active, internal output
// - bypass external: loop runs, external reference drives output
// - bypass external low power: loop and debug clock off unless debug active, external output
// - stop: loop off, no system or debug clock, references per stop enables
// - clock select bits 7:6 pick loop, internal, external; code 11 as 00
// - reference divider bits 5:3 divide by 1 up to 128, reset 000
// - reference select bit 2: one internal, zero external
// - bit 1 enables the internal reference clock output
// - bit 0 keeps internal reference alive in stop when enabled or in use
// - bus clock divider field resets to divide by two
// - clock mode status shows source in use, lagging the select field
package fcs_pkg;
  //==========================================================================
  // timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int IRC_PERIOD_NS = 31250;
  localparam int IRC_CYC = IRC_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TRIM_W = 9;
  localparam int TRIM_MID = 256;
  localparam logic [10:0] IRC_BASE = 11'(IRC_CYC - TRIM_MID);
  localparam int EXT_REF_MAX_KHZ = 5000;
  localparam int EXT_MIN_CYC = 1000000 / (EXT_REF_MAX_KHZ * CLK_PERIOD_NS);
  localparam logic [7:0] DCO_PER_MIN = 8'h02;
  localparam logic [7:0] DCO_PER_RST = 8'h14;
  localparam logic [7:0] DCO_PER_MAX = 8'hff;
  //==========================================================================
  // register map
  localparam int ADDR_W = 4;
  localparam logic [3:0] ADDR_CTRL1 = 4'h0;
  localparam logic [3:0] ADDR_CTRL2 = 4'h4;
  localparam logic [3:0] ADDR_STAT = 4'h8;
  localparam logic [7:0] CTRL1_RST = 8'h04;
  localparam logic [7:0] CTRL2_RST = 8'h40;
  localparam logic [7:0] CTRL1_FIXED = 8'h06;
  localparam logic [1:0] DIV_BY_TWO = 2'h1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  //==========================================================================
  // types
  typedef enum logic [1:0] {
    SRC_LOOP = 2'b00,
    SRC_INT = 2'b01,
    SRC_EXT = 2'b10
  } fcs_src_t;
  typedef struct packed {
    logic [1:0] clock_select;
    logic [2:0] reference_divider;
    logic internal_reference_select;
    logic internal_ref_output_enable;
    logic internal_ref_stop_enable;
  } fcs_ctrl1_t;
  typedef struct packed {
    logic [1:0] bus_clock_divider;
    logic range_hi;
    logic high_gain;
    logic low_power;
    logic erefs;
    logic erclken;
    logic erefsten;
  } fcs_ctrl2_t;
endpackage : fcs_pkg

// ---- hdl/fcs_pulse_div.sv ----
// pulse divider: passes one of every 1, 2, 4 or 8 enable pulses
`timescale 1ns/1ps
module fcs_pulse_div
  import fcs_pkg::*;
#(
  parameter logic [1:0] RST_CODE = DIV_BY_TWO
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_en,
  input wire logic [1:0] i_code,
  output logic o_en
);
  logic [2:0] cnt_r;
  logic [1:0] code_r;
  logic [2:0] lim;
  logic o_en_r;

  assign lim = 3'((4'h1 << code_r) - 4'h1);
  assign o_en = o_en_r;

  // count source pulses, take a new ratio only at wrap
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_r <= 3'h0;
      code_r <= RST_CODE;
    end else if (i_en) begin
      if (cnt_r == lim) begin
        cnt_r <= 3'h0;
        code_r <= i_code;
      end else begin
        cnt_r <= cnt_r + 3'h1;
      end
    end
  end

  // one output pulse per full ratio
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_en_r <= 1'b0;
    end else begin
      o_en_r <= i_en && (cnt_r == lim);
    end
  end
endmodule : fcs_pulse_div

// ---- hdl/fcs_clock_unit.sv ----
// top of the clock source unit: registers, loop, source select, dividers
`timescale 1ns/1ps
module fcs_clock_unit
  import fcs_pkg::*;
#(
  parameter int FLL_MULT = 64
) (
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  input wire logic I_EXT_REF,
  input wire logic I_STOP,
  input wire logic I_DBG_ACTIVE,
  input wire logic [TRIM_W-1:0] I_TRIM,
  input wire logic [ADDR_W-1:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic [ADDR_W-1:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY,
  output logic O_SYS_CLK_EN,
  output logic O_BUS_CLK_EN,
  output logic O_DBG_CLK_EN,
  output logic O_IREF_CLK_EN,
  output logic O_LOOP_ON
);
  //==========================================================================
  // elaboration checks
  if (FLL_MULT < 1 || FLL_MULT > 1000) begin : g_chk_mult
    $error("FLL_MULT out of range");
  end
  if (EXT_MIN_CYC < 4) begin : g_chk_ext
    $error("reference too fast for the core clock");
  end

  localparam logic [9:0] MULT = 10'(FLL_MULT);

  function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
    return (a == ADDR_CTRL1) || (a == ADDR_CTRL2) || (a == ADDR_STAT);
  endfunction : addr_ok

  function automatic fcs_src_t src_of(input logic [1:0] clock_select);
    unique case (clock_select)
      2'b01: return SRC_INT;
      2'b10: return SRC_EXT;
      default: return SRC_LOOP;
    endcase
  endfunction : src_of

  //==========================================================================
  // register bus slave
  fcs_ctrl1_t ctrl1_r;
  fcs_ctrl2_t ctrl2_r;
  logic [1:0] stat_meta_r;
  logic [1:0] stat_src_r;
  logic aw_hold_r;
  logic w_hold_r;
  logic wr_go;
  logic [ADDR_W-1:0] awaddr_r;
  logic [7:0] wbyte_r;
  logic wstrb0_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [1:0] rresp_r;
  logic [31:0] rdata_r;

  assign O_AWREADY = !aw_hold_r && !bvalid_r;
  assign O_WREADY = !w_hold_r && !bvalid_r;
  assign O_ARREADY = !rvalid_r;
  assign O_BVALID = bvalid_r;
  assign O_BRESP = bresp_r;
  assign O_RVALID = rvalid_r;
  assign O_RRESP = rresp_r;
  assign O_RDATA = rdata_r;
  assign wr_go = aw_hold_r && w_hold_r && !bvalid_r;

  // write address holding
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      aw_hold_r <= 1'b0;
      awaddr_r <= '0;
    end else if (O_AWREADY && I_AWVALID) begin
      aw_hold_r <= 1'b1;
      awaddr_r <= I_AWADDR;
    end else if (wr_go) begin
      aw_hold_r <= 1'b0;
    end
  end

  // write data holding, low byte lane only
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      w_hold_r <= 1'b0;
      wbyte_r <= 8'h00;
      wstrb0_r <= 1'b0;
    end else if (O_WREADY && I_WVALID) begin
      w_hold_r <= 1'b1;
      wbyte_r <= I_WDATA[7:0];
      wstrb0_r <= I_WSTRB[0];
    end else if (wr_go) begin
      w_hold_r <= 1'b0;
    end
  end

  // write response
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r <= addr_ok(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
    end else if (I_BREADY) begin
      bvalid_r <= 1'b0;
    end
  end

  // control registers
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      ctrl1_r <= CTRL1_RST;
      ctrl2_r <= CTRL2_RST;
    end else if (wr_go && wstrb0_r) begin
      if (awaddr_r == ADDR_CTRL1) begin
        ctrl1_r <= fcs_ctrl1_t'(wbyte_r);
      end
      if (awaddr_r == ADDR_CTRL2) begin
        ctrl2_r <= fcs_ctrl2_t'(wbyte_r);
      end
    end
  end

  // read channel, one cycle answer
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      rvalid_r <= 1'b0;
      rresp_r <= RESP_OKAY;
      rdata_r <= 32'h0;
    end else if (O_ARREADY && I_ARVALID) begin
      rvalid_r <= 1'b1;
      rresp_r <= addr_ok(I_ARADDR) ? RESP_OKAY : RESP_SLVERR;
      case (I_ARADDR)
        ADDR_CTRL1: rdata_r <= {24'h0, ctrl1_r | CTRL1_FIXED};
        ADDR_CTRL2: rdata_r <= {24'h0, ctrl2_r};
        ADDR_STAT: rdata_r <= {24'h0, 4'h0, stat_src_r, 2'h0};
        default: rdata_r <= 32'h0;
      endcase
    end else if (I_RREADY) begin
      rvalid_r <= 1'b0;
    end
  end

  //==========================================================================
  // references
  logic ext_s1_r;
  logic ext_s2_r;
  logic ext_s3_r;
  logic ext_lvl_r;
  logic ext_run;
  logic ext_pulse;
  logic [10:0] irc_cnt_r;
  logic [10:0] irc_lim;
  logic irc_run;
  logic irc_pulse;
  logic was_int_r;
  logic was_ext_r;
  fcs_src_t sel_src_r;
  fcs_src_t req_src;

  // external reference synchroniser, edge once stages two and three agree
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_s3_r <= 1'b0;
      ext_lvl_r <= 1'b0;
    end else begin
      ext_s1_r <= I_EXT_REF;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
      if (ext_s2_r == ext_s3_r) begin
        ext_lvl_r <= ext_s3_r;
      end
    end
  end

  // external reference alive in stop only with its stop enable and either its enable or use
  assign ext_run = !I_STOP || (ctrl2_r.erefsten && (ctrl2_r.erclken || was_ext_r));
  assign ext_pulse = ext_run && (ext_s2_r == ext_s3_r) && ext_s3_r && !ext_lvl_r;

  // internal reference oscillator, trimmed period
  assign irc_lim = IRC_BASE + 11'(I_TRIM);
  assign irc_run = !I_STOP || (ctrl1_r.internal_ref_stop_enable && (ctrl1_r.internal_ref_output_enable || was_int_r));
  assign irc_pulse = irc_run && (irc_cnt_r >= irc_lim - 11'h1);

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST || !irc_run || irc_pulse) begin
      irc_cnt_r <= 11'h0;
    end else begin
      irc_cnt_r <= irc_cnt_r + 11'h1;
    end
  end

  // remember which reference was in use when stop arrived
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      was_int_r <= 1'b1;
      was_ext_r <= 1'b0;
    end else if (!I_STOP) begin
      was_int_r <= (sel_src_r == SRC_INT) || (sel_src_r == SRC_LOOP && ctrl1_r.internal_reference_select);
      was_ext_r <= (sel_src_r == SRC_EXT) || (sel_src_r == SRC_LOOP && !ctrl1_r.internal_reference_select);
    end
  end

  // internal reference output when enabled
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      O_IREF_CLK_EN <= 1'b0;
    end else begin
      O_IREF_CLK_EN <= irc_pulse && ctrl1_r.internal_ref_output_enable;
    end
  end

  //==========================================================================
  // frequency locked loop
  logic loop_on;
  logic ref_pulse;
  logic ref_evt;
  logic [6:0] reference_divider_cnt_r;
  logic [6:0] reference_divider_lim;
  logic [7:0] dco_cnt_r;
  logic [7:0] dco_per_r;
  logic dco_pulse;
  logic [9:0] tick_r;

  assign req_src = src_of(ctrl1_r.clock_select);
  // loop kept on outside stop unless a low power bypass mode holds and debug is idle
  assign loop_on = !I_STOP && (sel_src_r == SRC_LOOP || req_src == SRC_LOOP
                   || !ctrl2_r.low_power || I_DBG_ACTIVE);
  assign ref_pulse = ctrl1_r.internal_reference_select ? irc_pulse : ext_pulse;
  assign reference_divider_lim = 7'((8'h1 << ctrl1_r.reference_divider) - 8'h1);
  assign ref_evt = loop_on && ref_pulse && (reference_divider_cnt_r >= reference_divider_lim);
  assign dco_pulse = loop_on && (dco_cnt_r >= dco_per_r - 8'h1);

  // reference divider, power of two
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST || !loop_on || ref_evt) begin
      reference_divider_cnt_r <= 7'h0;
    end else if (ref_pulse) begin
      reference_divider_cnt_r <= reference_divider_cnt_r + 7'h1;
    end
  end

  // controlled oscillator
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST || !loop_on || dco_pulse) begin
      dco_cnt_r <= 8'h0;
    end else begin
      dco_cnt_r <= dco_cnt_r + 8'h1;
    end
  end

  // count oscillator ticks per divided reference period
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST || ref_evt) begin
      tick_r <= 10'h0;
    end else if (dco_pulse && tick_r != 10'h3ff) begin
      tick_r <= tick_r + 10'h1;
    end
  end

  // steer the oscillator period toward the target ratio
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      dco_per_r <= DCO_PER_RST;
    end else if (ref_evt) begin
      if (tick_r < MULT && dco_per_r > DCO_PER_MIN) begin
        dco_per_r <= dco_per_r - 8'h1;
      end else if (tick_r > MULT && dco_per_r != DCO_PER_MAX) begin
        dco_per_r <= dco_per_r + 8'h1;
      end
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      O_LOOP_ON <= 1'b0;
    end else begin
      O_LOOP_ON <= loop_on;
    end
  end

  //==========================================================================
  // source select and output dividers
  logic src_pulse;
  logic drop_r;
  logic sys_in;

  always_comb begin
    unique case (sel_src_r)
      SRC_INT: src_pulse = irc_pulse;
      SRC_EXT: src_pulse = ext_pulse;
      default: src_pulse = dco_pulse;
    endcase
  end

  // switch on an old source pulse or in stop, drop the first new pulse
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      sel_src_r <= SRC_LOOP;
      drop_r <= 1'b0;
    end else if (req_src != sel_src_r && (src_pulse || I_STOP)) begin
      sel_src_r <= req_src;
      drop_r <= 1'b1;
    end else if (src_pulse) begin
      drop_r <= 1'b0;
    end
  end

  // status follows the applied source through two stages
  always_ff @(posedge I_CORE_CLK) begin
    if (I_RST) begin
      stat_meta_r <= 2'h0;
      stat_src_r <= 2'h0;
    end else begin
      stat_meta_r <= sel_src_r;
      stat_src_r <= stat_meta_r;
    end
  end

  assign sys_in = src_pulse && !drop_r && !I_STOP;

  fcs_pulse_div #(.RST_CODE(DIV_BY_TWO)) u_sys_div (
    .i_clk(I_CORE_CLK),
    .i_rst(I_RST),
    .i_en(sys_in),
    .i_code(ctrl2_r.bus_clock_divider),
    .o_en(O_SYS_CLK_EN)
  );

  fcs_pulse_div #(.RST_CODE(DIV_BY_TWO)) u_bus_div (
    .i_clk(I_CORE_CLK),
    .i_rst(I_RST),
    .i_en(O_SYS_CLK_EN),
    .i_code(DIV_BY_TWO),
    .o_en(O_BUS_CLK_EN)
  );

  fcs_pulse_div #(.RST_CODE(DIV_BY_TWO)) u_dbg_div (
    .i_clk(I_CORE_CLK),
    .i_rst(I_RST),
    .i_en(dco_pulse),
    .i_code(DIV_BY_TWO),
    .o_en(O_DBG_CLK_EN)
  );

  //==========================================================================
  // assertions
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RST);

  a_reset_engaged: assert property (
    $past(I_RST) |-> ctrl1_r == CTRL1_RST && sel_src_r == SRC_LOOP)
    else $error("reset did not give engaged internal mode");
  a_bus_clock_divider_reset: assert property (
    $past(I_RST) |-> ctrl2_r.bus_clock_divider == DIV_BY_TWO)
    else $error("bus divider not divide by two after reset");
  a_read_ones: assert property (
    (O_ARREADY && I_ARVALID && I_ARADDR == ADDR_CTRL1) |=> O_RDATA[2:1] == 2'b11)
    else $error("fixed bits did not read as one");
  a_bus_half: assert property (
    O_BUS_CLK_EN |-> $past(O_SYS_CLK_EN))
    else $error("bus pulse without system pulse");
  a_sys_no_runt: assert property (
    O_SYS_CLK_EN |=> !O_SYS_CLK_EN)
    else $error("runt on system clock");
  a_dbg_half: assert property (
    O_DBG_CLK_EN |=> !O_DBG_CLK_EN [*3])
    else $error("debug clock faster than half oscillator");
  a_stop_quiet: assert property (
    I_STOP ##1 I_STOP |-> !O_SYS_CLK_EN && !O_DBG_CLK_EN && !O_LOOP_ON)
    else $error("clock active in stop");
  a_lp_loop_off: assert property (
    (sel_src_r != SRC_LOOP && req_src != SRC_LOOP && ctrl2_r.low_power
     && !I_DBG_ACTIVE) |=> !O_LOOP_ON)
    else $error("loop on in low power bypass");
  a_lp_no_debug: assert property (
    !O_LOOP_ON [*3] |-> !O_DBG_CLK_EN)
    else $error("debug clock with loop off");
  a_iref_gate: assert property (
    O_IREF_CLK_EN |-> $past(ctrl1_r.internal_ref_output_enable))
    else $error("internal reference output while disabled");
  a_status_lag: assert property (
    $changed(sel_src_r) |-> ##2 stat_src_r == $past(sel_src_r, 2))
    else $error("status not following applied source");

  c_switch_ext: cover property ($rose(sel_src_r == SRC_EXT));
  c_stop_entry: cover property ($rose(I_STOP) ##1 I_STOP);
  c_lp_int: cover property (sel_src_r == SRC_INT && !O_LOOP_ON);
  c_write_done: cover property (O_BVALID && I_BREADY);
endmodule : fcs_clock_unit

// ---- testbench/fcs_partner.sv ----
// partner: clock tree and debug side pulse counters, external reference source
`timescale 1ns/1ps
module fcs_partner (
  input wire logic i_clk,
  input wire logic i_clr,
  input wire logic i_sys,
  input wire logic i_bus,
  input wire logic i_dbg,
  input wire logic i_iref,
  output logic o_ext_ref,
  output logic [15:0] o_n_sys,
  output logic [15:0] o_n_bus,
  output logic [15:0] o_n_dbg,
  output logic [15:0] o_n_iref,
  output logic [15:0] o_gap,
  output logic o_b2b
);
  logic [1:0] ph_r = 2'h0;
  logic ext_r = 1'b0;
  logic [15:0] cnt_r = 16'h0;
  logic sys_d_r = 1'b0;
  assign o_ext_ref = ext_r;
  // external reference at the 5 mhz ceiling: a rising edge every 8 cycles
  always_ff @(posedge i_clk) begin
    ph_r <= ph_r + 2'h1;
    if (ph_r == 2'h3) ext_r <= ~ext_r;
  end
  // pulse counters, cleared at the start of each window
  always_ff @(posedge i_clk) begin
    if (i_clr) begin
      o_n_sys <= 16'h0;
      o_n_bus <= 16'h0;
      o_n_dbg <= 16'h0;
      o_n_iref <= 16'h0;
      o_b2b <= 1'b0;
    end else begin
      o_n_sys <= o_n_sys + 16'(i_sys);
      o_n_bus <= o_n_bus + 16'(i_bus);
      o_n_dbg <= o_n_dbg + 16'(i_dbg);
      o_n_iref <= o_n_iref + 16'(i_iref);
      if (i_sys && sys_d_r) o_b2b <= 1'b1;
    end
  end
  // spacing in cycles between the last two system pulses
  always_ff @(posedge i_clk) begin
    sys_d_r <= i_sys;
    cnt_r <= i_sys ? 16'h1 : cnt_r + 16'h1;
    if (i_sys) o_gap <= cnt_r;
  end
endmodule : fcs_partner

// ---- testbench/testbench.sv ----
// testbench: register bus, mode and divider scenarios of the clock unit
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_mismatch++; \
  $display("BAD %0t got %0h exp %0h", $time, (a), (e)); end end
module testbench;
  import fcs_pkg::*;
  //==========================================================================
  // signals
  logic I_CORE_CLK = 1'b0;
  logic I_RST = 1'b1;
  logic I_STOP = 1'b0;
  logic I_DBG_ACTIVE = 1'b0;
  logic [8:0] I_TRIM = 9'h100;
  logic [3:0] I_AWADDR = 4'h0;
  logic [3:0] I_ARADDR = 4'h0;
  logic [31:0] I_WDATA = 32'h0;
  logic I_AWVALID = 1'b0;
  logic I_WVALID = 1'b0;
  logic I_BREADY = 1'b0;
  logic I_ARVALID = 1'b0;
  logic I_RREADY = 1'b0;
  logic clr = 1'b0;
  logic I_EXT_REF, O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID, o_b2b;
  logic O_SYS_CLK_EN, O_BUS_CLK_EN, O_DBG_CLK_EN, O_IREF_CLK_EN, O_LOOP_ON;
  logic [1:0] O_BRESP, O_RRESP;
  logic [31:0] O_RDATA;
  logic [15:0] n_sys, n_bus, n_dbg, n_iref, gap;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cyc = 0;
  //==========================================================================
  // instances
  fcs_clock_unit dut (.I_CORE_CLK, .I_RST, .I_EXT_REF, .I_STOP, .I_DBG_ACTIVE, .I_TRIM,
    .I_AWADDR, .I_AWVALID, .O_AWREADY, .I_WDATA, .I_WSTRB(4'hf), .I_WVALID, .O_WREADY,
    .O_BRESP, .O_BVALID, .I_BREADY, .I_ARADDR, .I_ARVALID, .O_ARREADY, .O_RDATA,
    .O_RRESP, .O_RVALID, .I_RREADY, .O_SYS_CLK_EN, .O_BUS_CLK_EN, .O_DBG_CLK_EN,
    .O_IREF_CLK_EN, .O_LOOP_ON);
  fcs_partner far_side (.i_clk(I_CORE_CLK), .i_clr(clr), .i_sys(O_SYS_CLK_EN),
    .i_bus(O_BUS_CLK_EN), .i_dbg(O_DBG_CLK_EN), .i_iref(O_IREF_CLK_EN),
    .o_ext_ref(I_EXT_REF), .o_n_sys(n_sys), .o_n_bus(n_bus), .o_n_dbg(n_dbg),
    .o_n_iref(n_iref), .o_gap(gap), .o_b2b(o_b2b));
  //==========================================================================
  // clock and hang guard
  initial begin
    forever #12.5 I_CORE_CLK = ~I_CORE_CLK;
  end
  always @(posedge I_CORE_CLK) begin
    cyc++;
    if (cyc == 90000) begin
      n_mismatch++;
      test_done();
    end
  end
  //==========================================================================
  // bus tasks
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] r;
    @(posedge I_CORE_CLK);
    I_AWADDR <= a;
    I_WDATA <= {24'h0, d};
    I_AWVALID <= 1'b1;
    I_WVALID <= 1'b1;
    I_BREADY <= 1'b1;
    do begin
      @(negedge I_CORE_CLK);
      ta = I_AWVALID && O_AWREADY;
      tw = I_WVALID && O_WREADY;
      tb = O_BVALID;
      r = O_BRESP;
      @(posedge I_CORE_CLK);
      if (ta) I_AWVALID <= 1'b0;
      if (tw) I_WVALID <= 1'b0;
    end while (!tb);
    I_BREADY <= 1'b0;
    `CHK(r, er)
  endtask : wr
  task automatic rdc(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
    logic ta, tr;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge I_CORE_CLK);
    I_ARADDR <= a;
    I_ARVALID <= 1'b1;
    I_RREADY <= 1'b1;
    do begin
      @(negedge I_CORE_CLK);
      ta = I_ARVALID && O_ARREADY;
      tr = O_RVALID;
      d = O_RDATA;
      r = O_RRESP;
      @(posedge I_CORE_CLK);
      if (ta) I_ARVALID <= 1'b0;
    end while (!tr);
    I_RREADY <= 1'b0;
    `CHK(d, e)
    `CHK(r, er)
  endtask : rdc
  //==========================================================================
  // window helpers: settle, clear the counters, count, then sample
  task automatic win(input int n);
    repeat (1500) @(posedge I_CORE_CLK);
    clr <= 1'b1;
    @(posedge I_CORE_CLK);
    clr <= 1'b0;
    repeat (n) @(posedge I_CORE_CLK);
    @(negedge I_CORE_CLK);
  endtask : win
  task automatic chk_mode(input logic lp, input logic dbg, input logic sys);
    win(3000);
    `CHK(O_LOOP_ON, lp)
    `CHK(n_dbg != 16'h0, dbg)
    `CHK(n_sys != 16'h0, sys)
    `CHK(o_b2b, 1'b0)
    `CHK((n_bus == n_sys >> 1) || (n_bus == (n_sys + 16'h1) >> 1), 1'b1)
  endtask : chk_mode
  //==========================================================================
  // scenarios
  task automatic t_reset();
    rdc(ADDR_CTRL1, 32'h06, RESP_OKAY);
    rdc(ADDR_CTRL2, 32'h40, RESP_OKAY);
    rdc(ADDR_STAT, 32'h00, RESP_OKAY);
    wr(ADDR_CTRL1, 8'h38, RESP_OKAY);
    rdc(ADDR_CTRL1, 32'h3e, RESP_OKAY);
    wr(4'hc, 8'h55, RESP_SLVERR);
    rdc(4'hc, 32'h0, RESP_SLVERR);
    wr(ADDR_CTRL1, 8'h04, RESP_OKAY);
    chk_mode(1'b1, 1'b1, 1'b1);
  endtask : t_reset
  task automatic t_ext_div();
    wr(ADDR_CTRL1, 8'h80, RESP_OKAY);
    chk_mode(1'b1, 1'b1, 1'b1);
    rdc(ADDR_STAT, 32'h08, RESP_OKAY);
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_CTRL2, {2'(c), 6'h0}, RESP_OKAY);
      win(300);
      `CHK(gap, 16'd8 << c)
    end
  endtask : t_ext_div
  task automatic t_int();
    // back to divide by one, the last divider step left the source divided by eight
    wr(ADDR_CTRL2, 8'h00, RESP_OKAY);
    wr(ADDR_CTRL1, 8'h44, RESP_OKAY);
    chk_mode(1'b1, 1'b1, 1'b1);
    `CHK(gap, 16'(IRC_BASE) + 16'(I_TRIM))
    rdc(ADDR_STAT, 32'h04, RESP_OKAY);
    wr(ADDR_CTRL2, 8'h08, RESP_OKAY);
    chk_mode(1'b0, 1'b0, 1'b1);
    I_DBG_ACTIVE <= 1'b1;
    win(100);
    `CHK(O_LOOP_ON, 1'b1)
    I_DBG_ACTIVE <= 1'b0;
    wr(ADDR_CTRL1, 8'h80, RESP_OKAY);
    chk_mode(1'b0, 1'b0, 1'b1);
  endtask : t_int
  task automatic t_fee();
    wr(ADDR_CTRL2, 8'h40, RESP_OKAY);
    wr(ADDR_CTRL1, 8'h38, RESP_OKAY);
    chk_mode(1'b1, 1'b1, 1'b1);
    rdc(ADDR_STAT, 32'h00, RESP_OKAY);
    wr(ADDR_CTRL1, 8'hc4, RESP_OKAY);
    chk_mode(1'b1, 1'b1, 1'b1);
    rdc(ADDR_STAT, 32'h00, RESP_OKAY);
  endtask : t_fee
  task automatic t_stop();
    wr(ADDR_CTRL1, 8'h07, RESP_OKAY);
    I_STOP <= 1'b1;
    chk_mode(1'b0, 1'b0, 1'b0);
    `CHK(n_iref != 16'h0, 1'b1)
    wr(ADDR_CTRL1, 8'h06, RESP_OKAY);
    win(3000);
    `CHK(n_iref, 16'h0)
    I_STOP <= 1'b0;
    wr(ADDR_CTRL1, 8'h04, RESP_OKAY);
    win(3000);
    `CHK(n_iref, 16'h0)
    wr(ADDR_CTRL1, 8'h06, RESP_OKAY);
    win(3000);
    `CHK(n_iref != 16'h0, 1'b1)
  endtask : t_stop
  //==========================================================================
  // verdict
  task automatic test_done();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done
  // main sequence
  initial begin
    repeat (12) @(posedge I_CORE_CLK);
    I_RST <= 1'b0;
    t_reset();
    t_ext_div();
    t_int();
    t_fee();
    t_stop();
    test_done();
  end
endmodule : testbench
